// ### inc/sar_adc_pkg.sv
package sar_adc_pkg;
  // word size and span
  localparam int RESULT_BITS = 18;
  localparam int FULL_SCALE_LEVELS = 262144;
  // clock and conversion timing, clock period in ps
  localparam int CLK_PERIOD_PS = 4000;
  localparam int CONV_TIME_NS = 2000;
  // longest time, so rounded down
  localparam int CONV_CYCLES = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int STEP_CYCLES = CONV_CYCLES / RESULT_BITS;
  // whole busy window: all bit steps plus the load cycle
  localparam int BUSY_CYCLES = RESULT_BITS * STEP_CYCLES + 1;
  // 250ksps throughput, least time, rounded up
  localparam int MIN_CYCLE_NS = 4000;
  localparam int MIN_CYCLE_CYCLES = (MIN_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // field values
  localparam logic [8:0] STEP_LAST = 9'(STEP_CYCLES - 1);
  localparam logic [4:0] BIT_MSB = 5'h11;
  localparam logic [4:0] BIT_LSB = 5'h00;
  localparam logic [4:0] CHAIN_START = 5'h12;
  localparam logic [17:0] TRIAL_START = 18'h20000;
  localparam logic [17:0] SIGN_FLIP = 18'h20000;
  localparam logic [17:0] RESULT_RESET = 18'h00000;
  localparam logic [9:0] LEN_RESET = 10'h000;

  typedef enum {nap_state, convert_state, done_state} conv_state_type;

  // what the control side hands to the serial side
  typedef struct packed {
    logic clear;
    logic [RESULT_BITS-1:0] result;
  } link_load_type;
endpackage

// ### src/sar_serial_shift.sv
`timescale 1ns/100ps
module sar_serial_shift
  import sar_adc_pkg::*;
(
  input wire logic sck_in,
  input wire logic reset_in,
  input wire link_load_type load_in,
  input wire logic chain_in,
  output logic data_out
);
  logic link_rst;
  logic [4:0] edge_count_reg;
  logic [RESULT_BITS-1:0] chain_reg;

  // clear is held by the control side for the whole conversion, so the
  // sck logic needs no edge of its own to restart a frame
  assign link_rst = reset_in | load_in.clear;

  // own bits counted, saturating once chain data is reached
  always_ff @(posedge sck_in or posedge link_rst) begin
    if (link_rst) begin
      edge_count_reg <= 5'h00;
    end else if (edge_count_reg != CHAIN_START) begin
      edge_count_reg <= edge_count_reg + 5'h01;
    end
  end

  // chain input lines up behind the own result
  always_ff @(posedge sck_in or posedge link_rst) begin
    if (link_rst) begin
      chain_reg <= RESULT_RESET;
    end else begin
      chain_reg <= {chain_reg[RESULT_BITS-2:0], chain_in};
    end
  end

  // result is quasi-static while sck runs, so reading it here is safe
  assign data_out = (edge_count_reg < CHAIN_START) ?
                    load_in.result[BIT_MSB - edge_count_reg] :
                    chain_reg[RESULT_BITS-1];

  chk_chain_after_own: assert property (@(posedge sck_in) disable iff (link_rst)
    (edge_count_reg == CHAIN_START && $past(edge_count_reg) == BIT_MSB)
    |-> data_out == $past(chain_in, 18))
    else $error("first chain bit not behind own result");
endmodule // sar_serial_shift

// ### src/sar_conversion_control.sv
// Contract
// - convert strobe rise wakes and starts conversion
// - acquire until strobe rise, then convert
// - binary search, one bit per step
// - load 18-bit code into shift path
// - on-chip timer paces the conversion
// - busy high during conversion, low after
// - result ready at once, 250ksps
// - nap automatically between conversions
// - chain low: pin gates data output
// - chain high: pin is chain input
// - shift on sck rise, MSB first
// - result coded in two's complement
// - read enable high releases data line
// - MSB on data output when busy falls
`timescale 1ns/100ps
module sar_conversion_control
  import sar_adc_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic sck_in,
  input wire logic convert_strobe_in,
  input wire logic chain_select_in,
  input wire logic read_enable_or_chain_in,
  input wire logic comparator_high_in,
  output logic busy_out,
  output logic nap_out,
  output logic acquire_out,
  output logic [RESULT_BITS-1:0] trial_code_out,
  output logic sdo_out,
  output logic sdo_oe_n_out
);
  // one binary-search step: keep or drop the bit under test, try the next
  function automatic logic [RESULT_BITS-1:0] sar_update(
    input logic [RESULT_BITS-1:0] trial,
    input logic [4:0] bit_idx,
    input logic keep
  );
    logic [RESULT_BITS-1:0] mask;
    logic [RESULT_BITS-1:0] next;
    mask = RESULT_BITS'(1) << bit_idx;
    next = keep ? trial : (trial & ~mask);
    if (bit_idx != BIT_LSB) begin
      next = next | (mask >> 1);
    end
    return next;
  endfunction

  // offset binary from the array into two's complement
  function automatic logic [RESULT_BITS-1:0] to_twos(input logic [RESULT_BITS-1:0] code);
    return code ^ SIGN_FLIP;
  endfunction

  conv_state_type state_reg;
  logic strobe_meta_reg;
  logic strobe_sync_reg;
  logic strobe_prev_reg;
  logic strobe_rise;
  logic chain_meta_reg;
  logic chain_mode_reg;
  logic rden_meta_reg;
  logic rden_sync_reg;
  logic busy_reg;
  logic [8:0] step_count_reg;
  logic [4:0] bit_idx_reg;
  logic [RESULT_BITS-1:0] trial_reg;
  logic [RESULT_BITS-1:0] result_reg;
  logic oe_n_reg;
  logic step_done;
  logic link_data;
  logic [9:0] busy_len_reg;
  link_load_type link_load;

  // strobe pin from the host passes two flops before use
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      strobe_meta_reg <= 1'b0;
      strobe_sync_reg <= 1'b0;
      strobe_prev_reg <= 1'b0;
    end else if (ce_in) begin
      strobe_meta_reg <= convert_strobe_in;
      strobe_sync_reg <= strobe_meta_reg;
      strobe_prev_reg <= strobe_sync_reg;
    end
  end

  // mode and read enable synchronisers
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      chain_meta_reg <= 1'b0;
      chain_mode_reg <= 1'b0;
      rden_meta_reg <= 1'b1;
      rden_sync_reg <= 1'b1;
    end else if (ce_in) begin
      chain_meta_reg <= chain_select_in;
      chain_mode_reg <= chain_meta_reg;
      rden_meta_reg <= read_enable_or_chain_in;
      rden_sync_reg <= rden_meta_reg;
    end
  end

  // edge only, a strobe held high does not start a second conversion
  assign strobe_rise = strobe_sync_reg & ~strobe_prev_reg;

  // internal step timer stands in for the conversion oscillator
  assign step_done = (step_count_reg == STEP_LAST);

  // conversion sequencer
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg <= nap_state;
    end else if (ce_in) begin
      case (state_reg)
        nap_state: begin
          if (strobe_rise) begin
            state_reg <= convert_state;
          end
        end
        convert_state: begin
          if (step_done && bit_idx_reg == BIT_LSB) begin
            state_reg <= done_state;
          end
        end
        done_state: begin
          state_reg <= nap_state;
        end
        default: begin
          state_reg <= nap_state;
        end
      endcase
    end
  end

  // busy spans the whole conversion; a strobe during it is ignored
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      busy_reg <= 1'b0;
    end else if (ce_in) begin
      if (state_reg == nap_state && strobe_rise) begin
        busy_reg <= 1'b1;
      end else if (state_reg == done_state) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // step timer, restarted for every bit
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      step_count_reg <= 9'h000;
    end else if (ce_in) begin
      if (state_reg != convert_state || step_done) begin
        step_count_reg <= 9'h000;
      end else begin
        step_count_reg <= step_count_reg + 9'h001;
      end
    end
  end

  // trial word drives the capacitor array, half scale first
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      trial_reg <= TRIAL_START;
      bit_idx_reg <= BIT_MSB;
    end else if (ce_in) begin
      if (state_reg == nap_state && strobe_rise) begin
        trial_reg <= TRIAL_START;
        bit_idx_reg <= BIT_MSB;
      end else if (state_reg == convert_state && step_done) begin
        // comparator is trusted settled by the end of each step
        trial_reg <= sar_update(trial_reg, bit_idx_reg, comparator_high_in);
        if (bit_idx_reg != BIT_LSB) begin
          bit_idx_reg <= bit_idx_reg - 5'h01;
        end
      end
    end
  end

  // result loaded on the edge where busy falls, no extra latency
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      result_reg <= RESULT_RESET;
    end else if (ce_in) begin
      if (state_reg == done_state) begin
        result_reg <= to_twos(trial_reg);
      end
    end
  end

  // output enable: chain mode always drives, normal mode follows the pin
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      oe_n_reg <= 1'b1;
    end else if (ce_in) begin
      if (chain_mode_reg) begin
        oe_n_reg <= 1'b0;
      end else begin
        oe_n_reg <= rden_sync_reg;
      end
    end
  end

  // busy length, read only by the checks below
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      busy_len_reg <= LEN_RESET;
    end else if (ce_in) begin
      busy_len_reg <= busy_reg ? busy_len_reg + 10'h001 : LEN_RESET;
    end
  end

  // serial side is held cleared while converting, so it restarts at MSB
  assign link_load.clear = busy_reg;
  assign link_load.result = result_reg;

  // shift path on the host clock; host keeps sck still until busy falls
  sar_serial_shift shift_inst (
    .sck_in(sck_in),
    .reset_in(reset_in),
    .load_in(link_load),
    .chain_in(read_enable_or_chain_in),
    .data_out(link_data)
  );

  // status and data pins
  assign busy_out = busy_reg;
  assign nap_out = (state_reg == nap_state);
  assign acquire_out = (state_reg == nap_state);
  assign trial_code_out = trial_reg;
  assign sdo_out = link_data;
  assign sdo_oe_n_out = oe_n_reg;

  // sequencing checks
  chk_strobe_starts_conv: assert property (@(posedge clk_in) disable iff (reset_in)
    (ce_in && strobe_rise && state_reg == nap_state) |=> busy_reg && state_reg == convert_state)
    else $error("strobe rise did not start a conversion");

  chk_nap_wakes: assert property (@(posedge clk_in) disable iff (reset_in)
    (ce_in && state_reg == nap_state && !strobe_rise)
    |=> state_reg == nap_state)
    else $error("left nap without a strobe");

  chk_acquire_stops: assert property (@(posedge clk_in) disable iff (reset_in)
    busy_reg |-> !acquire_out)
    else $error("acquiring while converting");

  chk_trial_start: assert property (@(posedge clk_in) disable iff (reset_in)
    $rose(busy_reg)
    |-> trial_reg == TRIAL_START && bit_idx_reg == BIT_MSB)
    else $error("search did not start at half scale");

  chk_trial_hold: assert property (@(posedge clk_in) disable iff (reset_in)
    (ce_in && state_reg == convert_state && !step_done)
    |=> $stable(trial_reg) && $stable(bit_idx_reg))
    else $error("trial word moved inside a step");

  chk_sar_bit_walk: assert property (@(posedge clk_in) disable iff (reset_in)
    (ce_in && state_reg == convert_state && step_done && bit_idx_reg != BIT_LSB)
    |=> bit_idx_reg == $past(bit_idx_reg) - 5'h01 && trial_reg[bit_idx_reg])
    else $error("bit step did not advance");

  chk_done_after_lsb: assert property (@(posedge clk_in) disable iff (reset_in)
    (ce_in && state_reg == convert_state && step_done && bit_idx_reg == BIT_LSB)
    |=> state_reg == done_state)
    else $error("no end of conversion after last bit");

  chk_step_count: assert property (@(posedge clk_in) disable iff (reset_in)
    (ce_in && state_reg == convert_state && !step_done)
    |=> step_count_reg == $past(step_count_reg) + 9'h001)
    else $error("step timer did not advance");

  chk_step_bound: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_reg == convert_state)
    |-> step_count_reg <= STEP_LAST)
    else $error("step timer ran past its end");

  chk_clock_freeze: assert property (@(posedge clk_in) disable iff (reset_in)
    !ce_in
    |=> $stable(state_reg) && $stable(step_count_reg) && $stable(busy_reg))
    else $error("state moved while clock enable low");

  chk_conv_duration: assert property (@(posedge clk_in) disable iff (reset_in)
    $fell(busy_reg) |-> busy_len_reg == 10'(BUSY_CYCLES))
    else $error("conversion length wrong");

  chk_busy_cause: assert property (@(posedge clk_in) disable iff (reset_in)
    $rose(busy_reg) |-> $past(strobe_rise) && $past(state_reg) == nap_state)
    else $error("busy rose without a strobe");

  chk_busy_holds: assert property (@(posedge clk_in) disable iff (reset_in)
    (busy_reg && state_reg != done_state)
    |=> busy_reg)
    else $error("busy dropped before conversion end");

  chk_result_twos: assert property (@(posedge clk_in) disable iff (reset_in)
    $fell(busy_reg) |-> (result_reg ^ $past(trial_reg)) == SIGN_FLIP)
    else $error("result not loaded in two's complement");

  chk_result_hold: assert property (@(posedge clk_in) disable iff (reset_in)
    (ce_in && busy_reg && state_reg != done_state)
    |=> $stable(result_reg))
    else $error("result changed during conversion");

  chk_result_idle: assert property (@(posedge clk_in) disable iff (reset_in)
    (ce_in && !busy_reg)
    |=> $stable(result_reg))
    else $error("result changed between conversions");

  chk_throughput_fit: assert property (@(posedge clk_in) disable iff (reset_in)
    busy_reg |-> busy_len_reg < 10'(MIN_CYCLE_CYCLES))
    else $error("conversion exceeds sample period");

  chk_nap_idle: assert property (@(posedge clk_in) disable iff (reset_in)
    (ce_in && state_reg == done_state) |=> nap_out && !busy_reg)
    else $error("no nap after conversion");

  chk_idle_naps: assert property (@(posedge clk_in) disable iff (reset_in)
    !busy_reg
    |-> nap_out && acquire_out)
    else $error("not napping while idle");

  // output pin checks
  chk_msb_at_fall: assert property (@(posedge clk_in) disable iff (reset_in)
    $fell(busy_reg) |-> sdo_out == result_reg[RESULT_BITS-1])
    else $error("msb not presented when busy fell");

  chk_normal_release: assert property (@(posedge clk_in) disable iff (reset_in)
    (ce_in && !chain_mode_reg && rden_sync_reg) |=> sdo_oe_n_out)
    else $error("data line not released");

  chk_normal_drive: assert property (@(posedge clk_in) disable iff (reset_in)
    (ce_in && !chain_mode_reg && !rden_sync_reg)
    |=> !sdo_oe_n_out)
    else $error("data line not driven while read enabled");

  chk_chain_drives: assert property (@(posedge clk_in) disable iff (reset_in)
    (ce_in && chain_mode_reg) |=> !sdo_oe_n_out)
    else $error("chain mode left data line released");
endmodule // sar_conversion_control

// ### sim/host_reader.sv
`timescale 1ns/100ps
module host_reader (
  input wire logic start_in,
  input wire logic [5:0] nbits_in,
  input wire logic [17:0] chain_word_in,
  input wire logic sdo_in,
  input wire logic sdo_oe_n_in,
  output logic sck_out,
  output logic chain_out,
  output logic [35:0] word_out,
  output logic done_out
);
  logic last_bit = 1'b0;
  logic line;
  // a released line shows the inverse of the last driven bit, never a stale copy
  always @(sdo_in or sdo_oe_n_in) if (!sdo_oe_n_in) last_bit = sdo_in;
  assign line = sdo_oe_n_in ? ~last_bit : sdo_in;
  // one frame per start: sck only runs inside frames, 15 ns period
  initial begin
    sck_out = 1'b0;
    chain_out = 1'b0;
    word_out = '0;
    done_out = 1'b0;
    forever begin
      @(posedge start_in);
      // sck phase kept apart from the system clock edges
      #1.3;
      word_out = '0;
      for (int i = 0; i < nbits_in; i++) begin
        chain_out = (i < 18) ? chain_word_in[17 - i] : 1'b0;
        #7.5;
        word_out = {word_out[34:0], line};
        sck_out = 1'b1;
        #7.5;
        sck_out = 1'b0;
      end
      // done held until the bench drops start, so no pulse can be missed
      done_out = 1'b1;
      @(negedge start_in);
      done_out = 1'b0;
    end
  end
endmodule // host_reader

// ### sim/sar_adc_conversion_serial_readout_tb.sv
`timescale 1ns/100ps
module sar_adc_conversion_serial_readout_tb;
  import sar_adc_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic convert_strobe_in = 1'b0;
  logic chain_select_in = 1'b0;
  logic read_enable_n = 1'b1;
  logic [17:0] sample = '0;
  logic [17:0] chain_word = '0;
  logic start = 1'b0;
  logic [5:0] nbits = 6'h12;
  logic ce = 1'b1;
  wire logic sck, chain_bit, busy_out, nap_out, acquire_out, sdo_out, sdo_oe_n_out, done;
  wire logic [RESULT_BITS-1:0] trial_code_out;
  wire logic [35:0] word;
  // shared pin: read enable in normal mode, chain data in chain mode
  wire logic pin_level = chain_select_in ? chain_bit : read_enable_n;
  // ideal comparator against the held sample, offset binary
  wire logic comparator_high = (sample ^ SIGN_FLIP) >= trial_code_out;
  logic [35:0] expect_q[$];
  int failures = 0;
  int checks = 0;

  sar_conversion_control i_dut (
    .clk_in(clk_in), .reset_in(reset_in), .ce_in(ce), .sck_in(sck),
    .convert_strobe_in(convert_strobe_in), .chain_select_in(chain_select_in),
    .read_enable_or_chain_in(pin_level), .comparator_high_in(comparator_high),
    .busy_out(busy_out), .nap_out(nap_out), .acquire_out(acquire_out),
    .trial_code_out(trial_code_out), .sdo_out(sdo_out), .sdo_oe_n_out(sdo_oe_n_out));

  host_reader i_host (
    .start_in(start), .nbits_in(nbits), .chain_word_in(chain_word), .sdo_in(sdo_out),
    .sdo_oe_n_in(sdo_oe_n_out), .sck_out(sck), .chain_out(chain_bit), .word_out(word), .done_out(done));

  // 250 MHz system clock
  initial begin
    forever #2 clk_in = ~clk_in;
  end

  task automatic check(input logic [35:0] exp, input logic [35:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic test_done();
    // a frame that never got compared is a mismatch too
    if (expect_q.size() != 0) failures++;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // one conversion, then a read frame when the line is enabled
  task automatic convert(input logic [17:0] s, input logic [17:0] cw);
    int n;
    @(negedge clk_in);
    sample = s;
    chain_word = cw;
    convert_strobe_in = 1'b1;
    n = 0;
    while (busy_out !== 1'b1 && n < 10) begin
      @(negedge clk_in);
      n++;
    end
    check(36'h1, 36'(busy_out));
    if (busy_out !== 1'b1) test_done();
    check(36'h0, 36'({nap_out, acquire_out}));
    n = 0;
    while (busy_out === 1'b1 && n < 600) begin
      @(negedge clk_in);
      n++;
      if (n == 6) convert_strobe_in = 1'b0;
    end
    if (n >= 600) begin
      failures++;
      test_done();
    end
    check(36'(BUSY_CYCLES), 36'(n));
    check(36'h3, 36'({nap_out, acquire_out}));
    check(36'(!chain_select_in && read_enable_n), 36'(sdo_oe_n_out));
    if (sdo_oe_n_out === 1'b0) begin
      // sck stays quiet until busy has fallen
      nbits = chain_select_in ? 6'h24 : 6'h12;
      expect_q.push_back(chain_select_in ? {s, cw} : {18'h0, s});
      start = 1'b1;
      n = 0;
      while (done !== 1'b1 && n < 300) begin
        @(negedge clk_in);
        n++;
      end
      start = 1'b0;
      if (n >= 300) begin
        failures++;
        test_done();
      end
    end
    // strobe to strobe stays above the 4 us cycle even when no frame is read
    repeat (520) @(negedge clk_in);
  endtask

  // compares each captured word with the oldest expectation
  initial begin
    forever begin
      @(posedge done);
      #1 check(expect_q.pop_front(), word);
    end
  end

  // main sequence: boundary codes, random codes, released line, chain mode
  initial begin
    logic [17:0] codes[4];
    codes = '{18'h20000, 18'h1FFFF, 18'h00000, 18'h3FFFF};
    void'($urandom(32'h939c));
    repeat (10) @(posedge clk_in);
    @(negedge clk_in) reset_in = 1'b0;
    repeat (5) @(negedge clk_in);
    check(36'h3, 36'({busy_out, nap_out, sdo_oe_n_out}));
    read_enable_n = 1'b0;
    repeat (5) @(negedge clk_in);
    check(36'h0, 36'(sdo_oe_n_out));
    // a strobe pulse that comes and goes while frozen is never seen
    ce = 1'b0;
    convert_strobe_in = 1'b1;
    repeat (4 + $urandom % 8) @(negedge clk_in);
    convert_strobe_in = 1'b0;
    repeat (3) @(negedge clk_in);
    ce = 1'b1;
    repeat (6) @(negedge clk_in);
    check(36'h1, 36'({busy_out, nap_out}));
    for (int i = 0; i < 10; i++) begin
      convert(i < 4 ? codes[i] : 18'($urandom), 18'h0);
    end
    read_enable_n = 1'b1;
    convert(18'($urandom), 18'h0);
    chain_select_in = 1'b1;
    repeat (5) @(negedge clk_in);
    check(36'(sdo_oe_n_out), 36'h0);
    for (int i = 0; i < 3; i++) begin
      convert(18'($urandom), 18'($urandom));
    end
    test_done();
  end
endmodule // sar_adc_conversion_serial_readout_tb
